/* File: design/uleb_top.sv */
// Purpose: receive error reporting, input noise filter and line-break send/receive
// Assumes: one 100 MHz clock; serial input synchronous to it; 8 data bits, LSB first
// Notes: bit time is 2*k base-clock ticks, base clock is clk_sys divided by 2^sel, sel above 10 taken as 10
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module uleb_top (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire uleb_pkg::uleb_req_s bus_req,
  output logic [7:0] rd_data,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output uleb_pkg::uleb_irq_s irq
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] serial_mode_reg_ff;
  logic [2:0] break_length_field_ff;
  logic break_tx_trigger_ff;
  logic break_rx_trigger_ff;
  logic break_rx_flag_ff;
  logic [2:0] rx_error_status_reg_ff;
  logic [7:0] rx_buffer_ff;
  logic [7:0] tx_buffer_ff;
  logic [7:0] brg_tx_ff;
  logic [7:0] brg_rx_ff;
  logic [3:0] clksel_ff;
  logic unread_ff;
  logic [7:0] rd_data_ff;
  uleb_pkg::uleb_irq_s irq_ff;

  // mode decode
  wire unit_power_bit = serial_mode_reg_ff[uleb_pkg::MODE_POWER];
  wire tx_enable_bit = serial_mode_reg_ff[uleb_pkg::MODE_TXEN];
  wire rx_enable_bit = serial_mode_reg_ff[uleb_pkg::MODE_RXEN];
  wire error_irq_merge_bit = serial_mode_reg_ff[uleb_pkg::MODE_MERGE];
  wire [1:0] par_mode = serial_mode_reg_ff[uleb_pkg::MODE_PAR_HI:uleb_pkg::MODE_PAR_LO];
  wire tx_on = unit_power_bit & tx_enable_bit;
  wire rx_on = unit_power_bit & rx_enable_bit;
  wire par_used = (par_mode != uleb_pkg::ULEB_PAR_NONE);

  // bus decode
  wire wr_mode = bus_req.wr & (bus_req.addr == uleb_pkg::OFS_MODE);
  wire wr_ctrl = bus_req.wr & (bus_req.addr == uleb_pkg::OFS_CTRL);
  wire wr_txbuf = bus_req.wr & (bus_req.addr == uleb_pkg::OFS_TXBUF);
  wire rd_stat = bus_req.rd & (bus_req.addr == uleb_pkg::OFS_STAT);
  wire rd_rxbuf = bus_req.rd & (bus_req.addr == uleb_pkg::OFS_RXBUF);

  // ----------------------------------------------------------------
  // base clock selector
  // ----------------------------------------------------------------
  // low prescaler bits that must be zero for a tick; clamped selector
  function automatic logic [9:0] sel_mask(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > uleb_pkg::CLKSEL_MAX) ? uleb_pkg::CLKSEL_MAX : sel;
    sel_mask = 10'(~(10'h3FF << s));
  endfunction

  logic [9:0] pre_ff;
  wire [9:0] pre_mask = sel_mask(clksel_ff);
  wire tick = unit_power_bit & ((pre_ff & pre_mask) == 10'h000); // RQ21

  // base clock stands still while the unit is unpowered
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pre_ff <= 10'h000;
    end else begin
      pre_ff <= unit_power_bit ? 10'(pre_ff + 10'h001) : 10'h000;
    end
  end

  // ----------------------------------------------------------------
  // noise filter
  // ----------------------------------------------------------------
  logic smp0_ff;
  logic smp1_ff;
  logic serial_in_signal_ff;

  // two agreeing samples needed; costs two ticks of latency
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      smp0_ff <= 1'b1;
      smp1_ff <= 1'b1;
      serial_in_signal_ff <= 1'b1;
    end else if (tick) begin
      smp0_ff <= serial_in_pin; // RQ7
      smp1_ff <= smp0_ff;
      if (smp0_ff == smp1_ff) begin
        serial_in_signal_ff <= smp1_ff; // RQ8
      end
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  uleb_pkg::uleb_rx_e rx_st_ff;
  logic [8:0] rx_cnt_ff;
  logic [2:0] rx_bit_ff;
  logic [7:0] rx_shift_reg_ff;
  logic rx_pe_ff;
  logic [4:0] brk_width_ff;

  wire rxd = serial_in_signal_ff;
  wire rx_start_edge = (rx_st_ff == uleb_pkg::ULEB_RX_IDLE) & ~rxd;
  wire rx_half = (rx_cnt_ff == 9'({1'b0, brg_rx_ff} - 9'h001));
  wire rx_full = (rx_cnt_ff == 9'({brg_rx_ff, 1'b0} - 9'h001));
  wire rx_smp_start = tick & (rx_st_ff == uleb_pkg::ULEB_RX_START) & rx_half;
  wire rx_smp_bit = tick & (rx_st_ff != uleb_pkg::ULEB_RX_START) & rx_full;
  wire rx_stop_evt = rx_smp_bit & (rx_st_ff == uleb_pkg::ULEB_RX_STOP);
  wire brk_end = rx_smp_bit & (rx_st_ff == uleb_pkg::ULEB_RX_BRK) & rxd;
  wire brk_ok = brk_end & (brk_width_ff >= uleb_pkg::BREAK_MIN_RX); // RQ17
  wire par_calc = ^rx_shift_reg_ff ^ rxd;
  wire par_bad = ((par_mode == uleb_pkg::ULEB_PAR_EVEN) & par_calc) |
                 ((par_mode == uleb_pkg::ULEB_PAR_ODD) & ~par_calc); // RQ3

  // error causes, taken at the one stop bit
  wire err_frm = ~rxd; // RQ4 RQ23
  wire err_ovr = unread_ff; // RQ5
  wire [2:0] err_set = rx_stop_evt ? {rx_pe_ff, err_frm, err_ovr} : 3'h0; // RQ1
  wire err_any = |err_set;
  wire rx_write = rx_stop_evt & ~err_ovr; // RQ22

  // receive shifting; the counter is cleared while off and at each start edge
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rx_st_ff <= uleb_pkg::ULEB_RX_IDLE;
      rx_cnt_ff <= 9'h000;
      rx_bit_ff <= 3'h0;
      rx_shift_reg_ff <= 8'h00;
      rx_pe_ff <= 1'b0;
      brk_width_ff <= 5'h00;
    end else if (!rx_on) begin
      rx_st_ff <= uleb_pkg::ULEB_RX_IDLE;
      rx_cnt_ff <= 9'h000;
    end else if (tick) begin
      rx_cnt_ff <= (rx_smp_start | rx_smp_bit | rx_start_edge) ? 9'h000 :
                   9'(rx_cnt_ff + 9'h001);
      case (rx_st_ff)
        uleb_pkg::ULEB_RX_IDLE: begin
          if (~rxd) begin
            rx_st_ff <= uleb_pkg::ULEB_RX_START; // RQ16
          end
        end
        uleb_pkg::ULEB_RX_START: begin
          if (rx_half) begin
            rx_bit_ff <= 3'h0;
            rx_pe_ff <= 1'b0;
            brk_width_ff <= 5'h01;
            if (rxd) begin
              rx_st_ff <= uleb_pkg::ULEB_RX_IDLE;
            end else if (break_rx_trigger_ff) begin
              rx_st_ff <= uleb_pkg::ULEB_RX_BRK; // RQ16
            end else begin
              rx_st_ff <= uleb_pkg::ULEB_RX_DATA;
            end
          end
        end
        uleb_pkg::ULEB_RX_DATA: begin
          if (rx_full) begin
            rx_shift_reg_ff <= {rxd, rx_shift_reg_ff[7:1]};
            rx_bit_ff <= 3'(rx_bit_ff + 3'h1);
            if (rx_bit_ff == uleb_pkg::LAST_DATA_BIT) begin
              rx_st_ff <= par_used ? uleb_pkg::ULEB_RX_PAR : uleb_pkg::ULEB_RX_STOP;
            end
          end
        end
        uleb_pkg::ULEB_RX_PAR: begin
          if (rx_full) begin
            rx_pe_ff <= par_bad;
            rx_st_ff <= uleb_pkg::ULEB_RX_STOP;
          end
        end
        uleb_pkg::ULEB_RX_STOP: begin
          if (rx_full) begin
            rx_st_ff <= uleb_pkg::ULEB_RX_IDLE;
          end
        end
        uleb_pkg::ULEB_RX_BRK: begin
          if (rx_full) begin
            if (rxd) begin
              rx_st_ff <= uleb_pkg::ULEB_RX_IDLE; // RQ20
            end else if (brk_width_ff != 5'h1F) begin
              brk_width_ff <= 5'(brk_width_ff + 5'h01);
            end
          end
        end
        default: begin
          rx_st_ff <= uleb_pkg::ULEB_RX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  uleb_pkg::uleb_tx_e tx_st_ff;
  logic [8:0] tx_cnt_ff;
  logic [4:0] tx_bit_ff;
  logic [7:0] tx_shift_ff;
  logic tx_out_ff;

  wire tx_idle = (tx_st_ff == uleb_pkg::ULEB_TX_IDLE);
  wire tx_load = tx_on & tx_idle & wr_txbuf; // RQ14
  wire brk_go = tx_on & tx_idle & wr_ctrl & bus_req.wdata[uleb_pkg::CTRL_BRK_TX]; // RQ10
  wire tx_full = (tx_cnt_ff == 9'({brg_tx_ff, 1'b0} - 9'h001));
  wire tx_edge = tick & tx_full;
  wire tx_par = (par_mode == uleb_pkg::ULEB_PAR_EVEN) ? ^tx_buffer_ff :
                (par_mode == uleb_pkg::ULEB_PAR_ODD) ? ~^tx_buffer_ff : 1'b0;
  wire [4:0] brk_len = 5'(uleb_pkg::BREAK_BASE + {2'b00, break_length_field_ff}); // RQ12
  wire tx_frame_end = tx_edge & (tx_st_ff == uleb_pkg::ULEB_TX_STOP);
  wire brk_tx_end = tx_edge & (tx_st_ff == uleb_pkg::ULEB_TX_BRK) &
                    (tx_bit_ff == 5'(brk_len - 5'h01)); // RQ11

  // transmit sequencing; counter cleared when off and on each start
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_st_ff <= uleb_pkg::ULEB_TX_IDLE;
      tx_cnt_ff <= 9'h000;
      tx_bit_ff <= 5'h00;
      tx_shift_ff <= 8'h00;
    end else if (!tx_on) begin
      tx_st_ff <= uleb_pkg::ULEB_TX_IDLE;
      tx_cnt_ff <= 9'h000;
    end else if (tx_load | brk_go) begin
      tx_st_ff <= tx_load ? uleb_pkg::ULEB_TX_START : uleb_pkg::ULEB_TX_BRK;
      tx_shift_ff <= bus_req.wdata;
      tx_cnt_ff <= 9'h000;
      tx_bit_ff <= 5'h00;
    end else if (tick) begin
      tx_cnt_ff <= tx_full ? 9'h000 : 9'(tx_cnt_ff + 9'h001);
      if (tx_full) begin
        case (tx_st_ff)
          uleb_pkg::ULEB_TX_START: begin
            tx_st_ff <= uleb_pkg::ULEB_TX_DATA;
          end
          uleb_pkg::ULEB_TX_DATA: begin
            tx_shift_ff <= {1'b1, tx_shift_ff[7:1]};
            tx_bit_ff <= 5'(tx_bit_ff + 5'h01);
            if (tx_bit_ff[2:0] == uleb_pkg::LAST_DATA_BIT) begin
              tx_st_ff <= par_used ? uleb_pkg::ULEB_TX_PAR : uleb_pkg::ULEB_TX_STOP;
            end
          end
          uleb_pkg::ULEB_TX_PAR: begin
            tx_st_ff <= uleb_pkg::ULEB_TX_STOP;
          end
          uleb_pkg::ULEB_TX_STOP: begin
            tx_st_ff <= uleb_pkg::ULEB_TX_IDLE; // RQ14
          end
          uleb_pkg::ULEB_TX_BRK: begin
            tx_bit_ff <= 5'(tx_bit_ff + 5'h01);
            if (brk_tx_end) begin
              tx_st_ff <= uleb_pkg::ULEB_TX_IDLE; // RQ13
            end
          end
          default: begin
            tx_st_ff <= uleb_pkg::ULEB_TX_IDLE;
          end
        endcase
      end
    end
  end

  // line level per state; idle and unpowered stay high
  wire tx_level = (tx_st_ff == uleb_pkg::ULEB_TX_START) ? 1'b0 :
                  (tx_st_ff == uleb_pkg::ULEB_TX_DATA) ? tx_shift_ff[0] :
                  (tx_st_ff == uleb_pkg::ULEB_TX_PAR) ? tx_par :
                  (tx_st_ff == uleb_pkg::ULEB_TX_BRK) ? 1'b0 : 1'b1; // RQ9 RQ11

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_out_ff <= 1'b1;
    end else begin
      tx_out_ff <= tx_on ? tx_level : 1'b1; // RQ9
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // error set wins over a read-clear in the same cycle
  wire [2:0] nxt_status = (rd_stat ? 3'h0 : rx_error_status_reg_ff) | err_set; // RQ2 RQ18
  wire nxt_unread = (unread_ff & ~rd_rxbuf) | rx_write;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      serial_mode_reg_ff <= 8'h00;
      break_length_field_ff <= 3'h0;
      break_tx_trigger_ff <= 1'b0;
      break_rx_trigger_ff <= 1'b0;
      break_rx_flag_ff <= 1'b0;
      rx_error_status_reg_ff <= 3'h0;
      rx_buffer_ff <= uleb_pkg::RST_RXBUF;
      tx_buffer_ff <= 8'h00;
      brg_tx_ff <= uleb_pkg::RST_BRG;
      brg_rx_ff <= uleb_pkg::RST_BRG;
      clksel_ff <= 4'h0;
      unread_ff <= 1'b0;
    end else begin
      rx_error_status_reg_ff <= nxt_status;
      unread_ff <= nxt_unread;
      if (rx_write) begin
        rx_buffer_ff <= rx_shift_reg_ff; // RQ19 RQ22
      end
      if (wr_mode) begin
        serial_mode_reg_ff <= bus_req.wdata;
      end
      if (wr_ctrl) begin
        break_length_field_ff <= bus_req.wdata[uleb_pkg::CTRL_LEN_HI:uleb_pkg::CTRL_LEN_LO];
      end
      if (tx_load) begin
        tx_buffer_ff <= bus_req.wdata;
      end
      if (bus_req.wr & (bus_req.addr == uleb_pkg::OFS_BRG_TX)) begin
        brg_tx_ff <= bus_req.wdata; // RQ21
      end
      if (bus_req.wr & (bus_req.addr == uleb_pkg::OFS_BRG_RX)) begin
        brg_rx_ff <= bus_req.wdata; // RQ21
      end
      if (bus_req.wr & (bus_req.addr == uleb_pkg::OFS_CLKSEL)) begin
        clksel_ff <= bus_req.wdata[3:0];
      end
      // transmit trigger self-clears at break end
      if (brk_go) begin
        break_tx_trigger_ff <= 1'b1;
      end else if (brk_tx_end | ~tx_on) begin
        break_tx_trigger_ff <= 1'b0; // RQ13
      end
      // receive trigger and flag persist until a long break
      if (wr_ctrl & rx_on & bus_req.wdata[uleb_pkg::CTRL_BRK_RX]) begin
        break_rx_trigger_ff <= 1'b1; // RQ15
      end else if (brk_ok) begin
        break_rx_trigger_ff <= 1'b0; // RQ17
      end
      if (rx_smp_start & ~rxd & break_rx_trigger_ff) begin
        break_rx_flag_ff <= 1'b1;
      end else if (brk_ok) begin
        break_rx_flag_ff <= 1'b0; // RQ17
      end
    end
  end

  // ----------------------------------------------------------------
  // read data and requests
  // ----------------------------------------------------------------
  wire [7:0] ctrl_view = {break_rx_flag_ff, break_rx_trigger_ff, break_tx_trigger_ff,
                          break_length_field_ff, 2'b00};
  wire [7:0] rd_mux = (bus_req.addr == uleb_pkg::OFS_MODE) ? serial_mode_reg_ff :
                      (bus_req.addr == uleb_pkg::OFS_CTRL) ? ctrl_view :
                      (bus_req.addr == uleb_pkg::OFS_STAT) ? {5'h00, rx_error_status_reg_ff} :
                      (bus_req.addr == uleb_pkg::OFS_RXBUF) ? rx_buffer_ff :
                      (bus_req.addr == uleb_pkg::OFS_TXBUF) ? tx_buffer_ff :
                      (bus_req.addr == uleb_pkg::OFS_BRG_TX) ? brg_tx_ff :
                      (bus_req.addr == uleb_pkg::OFS_BRG_RX) ? brg_rx_ff :
                      {4'h0, clksel_ff};

  // merge bit folds errors into done, else they go apart
  wire nxt_rx_done = (rx_stop_evt & (error_irq_merge_bit | ~err_any)) | brk_ok; // RQ6 RQ17
  wire nxt_rx_err = rx_stop_evt & ~error_irq_merge_bit & err_any; // RQ1 RQ6

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_ff <= 8'h00;
      irq_ff <= '0;
    end else begin
      rd_data_ff <= bus_req.rd ? rd_mux : 8'h00;
      irq_ff.rx_done_irq <= nxt_rx_done;
      irq_ff.rx_error_irq <= nxt_rx_err;
      irq_ff.tx_done_irq <= tx_frame_end | brk_tx_end; // RQ13
    end
  end

  assign rd_data = rd_data_ff;
  assign irq = irq_ff;
  assign serial_out_pin = tx_out_ff;
endmodule

/* File: design/uleb_pkg.sv */
// Purpose: shared constants and types of the block
// Assumes: 8-bit registers on a plain address/strobe port
// Notes: offsets are word indices of the plain register port
// Notes on behaviour
// (RQ1) detect parity, framing, overrun; raise error request
// (RQ2) reading error status clears it
// (RQ3) parity mismatch against mode sets parity flag; here only odd and even modes check it, zero mode never sets the flag
// (RQ4) missing stop bit sets framing flag
// (RQ5) new frame before buffer read sets overrun
// (RQ6) merge bit selects separate or merged error request
// (RQ7) input changes only when two samples agree
// (RQ8) receive logic lags pin by two samples
// (RQ9) powered unit drives output high when idle
// (RQ10) break trigger write starts break transmission
// (RQ11) break holds output low 13 to 20 bits
// (RQ12) break length is 13 plus field value
// (RQ13) break end: done request, trigger clears
// (RQ14) transmitter idles until new data or trigger
// (RQ15) break-receive trigger write enables break reception
// (RQ16) break reception detects start bit normally
// (RQ17) break of 11+ bits: done, clear trigger, flag
// (RQ18) no error flags during break reception
// (RQ19) receive buffer untouched during break reception
// (RQ20) short break: no request, keep waiting
// (RQ21) clock selector, separate 8-bit transmit, receive counters
// (RQ22) stop bit: done request, buffer written unless overrun
// (RQ23) receiver always uses a single stop bit
// (RQ24) software reads status before buffer after errors
package uleb_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_MODE = 3'h0;
  localparam logic [2:0] OFS_CTRL = 3'h1;
  localparam logic [2:0] OFS_STAT = 3'h2;
  localparam logic [2:0] OFS_RXBUF = 3'h3;
  localparam logic [2:0] OFS_TXBUF = 3'h4;
  localparam logic [2:0] OFS_BRG_TX = 3'h5;
  localparam logic [2:0] OFS_BRG_RX = 3'h6;
  localparam logic [2:0] OFS_CLKSEL = 3'h7;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MODE_POWER = 7;
  localparam int MODE_TXEN = 6;
  localparam int MODE_RXEN = 5;
  localparam int MODE_PAR_HI = 4;
  localparam int MODE_PAR_LO = 3;
  localparam int MODE_MERGE = 0;
  localparam int CTRL_BRK_FLAG = 7;
  localparam int CTRL_BRK_RX = 6;
  localparam int CTRL_BRK_TX = 5;
  localparam int CTRL_LEN_HI = 4;
  localparam int CTRL_LEN_LO = 2;
  localparam int STAT_PAR = 2;
  localparam int STAT_FRM = 1;
  localparam int STAT_OVR = 0;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_RXBUF = 8'hFF;
  localparam logic [7:0] RST_BRG = 8'hFF;
  localparam logic [3:0] CLKSEL_MAX = 4'hA;
  localparam logic [4:0] BREAK_BASE = 5'h0D;
  localparam logic [4:0] BREAK_MIN_RX = 5'h0B;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;

  // parity modes
  typedef enum logic [1:0] {
    ULEB_PAR_NONE = 2'h0,
    ULEB_PAR_ZERO = 2'h1,
    ULEB_PAR_ODD = 2'h2,
    ULEB_PAR_EVEN = 2'h3
  } uleb_par_e;

  // receiver and transmitter states, gray from idle through parity to stop
  typedef enum logic [2:0] {
    ULEB_RX_IDLE = 3'h0,
    ULEB_RX_START = 3'h1,
    ULEB_RX_DATA = 3'h3,
    ULEB_RX_PAR = 3'h2,
    ULEB_RX_STOP = 3'h6,
    ULEB_RX_BRK = 3'h7
  } uleb_rx_e;

  typedef enum logic [2:0] {
    ULEB_TX_IDLE = 3'h0,
    ULEB_TX_START = 3'h1,
    ULEB_TX_DATA = 3'h3,
    ULEB_TX_PAR = 3'h2,
    ULEB_TX_STOP = 3'h6,
    ULEB_TX_BRK = 3'h4
  } uleb_tx_e;

  // register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } uleb_req_s;

  // interrupt request pulses
  typedef struct packed {
    logic rx_done_irq;
    logic rx_error_irq;
    logic tx_done_irq;
  } uleb_irq_s;
endpackage

/* File: verif/uleb_chk.sv */
// Purpose: port-level checks
// Assumes: clksel 0, baud count 8, one bit lasts BT cycles
// Notes: line-length bounds need that setting
`timescale 1ns/1ps
module uleb_chk #(
  parameter int BT = 16
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire uleb_pkg::uleb_req_s bus_req,
  input wire logic [7:0] rd_data,
  input wire logic serial_in_pin,
  input wire logic serial_out_pin,
  input wire uleb_pkg::uleb_irq_s irq
);
  // ----------------------------------------------------------------
  // run-length counters on both serial lines
  // ----------------------------------------------------------------
  logic [9:0] lo_cnt_ff;
  logic [7:0] hi_cnt_ff;
  wire logic [9:0] nxt_lo_cnt = serial_out_pin ? 10'h000 : (lo_cnt_ff + 10'h001);
  wire logic [7:0] nxt_hi_cnt = !serial_in_pin ? 8'h00 : 8'(hi_cnt_ff + 8'(hi_cnt_ff != 8'hFF));
  wire logic stat_rd = bus_req.rd && bus_req.addr == uleb_pkg::OFS_STAT && !irq.rx_error_irq &&
    !irq.rx_done_irq;

  // high count saturates so long idle never looks short
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lo_cnt_ff <= 10'h000;
      hi_cnt_ff <= 8'h00;
    end else begin
      lo_cnt_ff <= nxt_lo_cnt;
      hi_cnt_ff <= nxt_hi_cnt;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_done_pulse: assert property (irq.rx_done_irq |=> !irq.rx_done_irq)
    else $error("receive done longer than one cycle");
  a_err_pulse: assert property (irq.rx_error_irq |=> !irq.rx_error_irq)
    else $error("receive error longer than one cycle");
  a_err_alone: assert property (irq.rx_error_irq |-> !irq.rx_done_irq)
    else $error("error and done requests together");
  a_idle_high: assert property ($rose(rst_b) |-> serial_out_pin)
    else $error("output not high after reset");
  a_tx_idle_after: assert property (irq.tx_done_irq |=> ##1 serial_out_pin[*4])
    else $error("output not idle after transmit done");
  a_stat_clear: assert property (stat_rd ##1 stat_rd |=> rd_data == 8'h00)
    else $error("status not cleared by a read");
  a_rx_cause: assert property ((irq.rx_done_irq || irq.rx_error_irq) |-> hi_cnt_ff < 8'hC8)
    else $error("receive request without line activity");
  a_brk_max: assert property (lo_cnt_ff <= 10'(20 * BT))
    else $error("output low longer than the longest break");
  a_brk_range: assert property ($rose(serial_out_pin) |->
    (lo_cnt_ff <= 10'(10 * BT) || lo_cnt_ff >= 10'(13 * BT)))
    else $error("low run neither a frame nor a break");
endmodule

bind uleb_top uleb_chk #(.BT(16)) u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req),
  .rd_data(rd_data), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
  .irq(irq));

/* File: verif/uleb_node.sv */
// Purpose: remote node on the serial input
// Assumes: bit time BT cycles; tasks start just after a rising edge
// Notes: line idles high; one task at a time
`timescale 1ns/1ps
module uleb_node #(
  parameter int BT = 16
) (
  input wire logic clk_sys,
  output logic line_o
);
  initial line_o = 1'b1;

  // levels change by non-blocking assignment on the edge
  task automatic hold(input logic v, input int n);
    line_o <= v;
    repeat (n) @(posedge clk_sys);
  endtask

  // start, data lsb first, parity when enabled, then one stop bit
  task automatic send_frame(input logic [7:0] d, input logic par_en, input logic par_odd,
    input logic par_flip, input logic stop_v);
    hold(1'b0, BT);
    for (int i = 0; i < 8; i++) hold(d[i], BT);
    if (par_en) hold(^d ^ par_odd ^ par_flip, BT);
    // low stop cut short so it is not taken as a start
    hold(stop_v, stop_v ? BT : (3 * BT / 4));
    hold(1'b1, 2 * BT);
  endtask

  // low stretch as a line break
  task automatic send_low(input int nbits);
    hold(1'b0, nbits * BT);
    hold(1'b1, 3 * BT);
  endtask

  // toggles each cycle so no two samples agree
  task automatic noise(input int n);
    for (int i = 0; i < n; i++) hold(1'(i % 2), 1);
    hold(1'b1, 3 * BT);
  endtask
endmodule

/* File: verif/uleb_top_tb_top.sv */
// Purpose: self-checking bench
// Assumes: clksel 0, baud count 8: one bit is 16 cycles
// Notes: node model drives the input; breaks sent are timed here
`timescale 1ns/1ps
module uleb_top_tb_top;
  localparam int BT = 16;
  localparam logic [7:0] RST_VAL [8] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00};
  logic clk_sys, rst_b;
  uleb_pkg::uleb_req_s bus_req;
  logic [7:0] rd_data;
  logic serial_in_pin, serial_out_pin;
  uleb_pkg::uleb_irq_s irq;
  int n_errors;
  int samples_checked;
  int n_done, n_err, n_txd, cnt, e;
  logic [7:0] q, q2;

  uleb_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .irq(irq));
  uleb_node #(.BT(BT)) u_node (.clk_sys(clk_sys), .line_o(serial_in_pin));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // count pulses as they come so none is missed
  always @(posedge clk_sys) begin
    if (irq.rx_done_irq === 1'b1) n_done++;
    if (irq.rx_error_irq === 1'b1) n_err++;
    if (irq.tx_done_irq === 1'b1) n_txd++;
  end

  // ----------------------------------------------------------------
  // bus access and checks
  // ----------------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  // twice: two back-to-back reads; q1 first answer, q2o last
  task automatic rd(input logic [2:0] a, input logic twice, output logic [7:0] q1,
    output logic [7:0] q2o);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    #1 q1 = rd_data;
    if (twice) @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1 q2o = rd_data;
    @(posedge clk_sys);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic done_test(input string s);
    $display("test %s done at %0t", s, $time);
  endtask

  function automatic logic [7:0] par_stat(input int m);
    return (m >= 2) ? 8'h04 : 8'h00;
  endfunction

  // done count high byte, error count low byte
  function automatic logic [15:0] irq_exp(input logic err, input logic merge);
    return (err && !merge) ? 16'h0001 : 16'h0100;
  endfunction

  // one frame, after an unread one when pre is set (overrun)
  task automatic rx_case(input logic [7:0] md, input logic flip, input logic stop_v,
    input logic pre, input logic [7:0] st, input logic [15:0] ie);
    int d0, e0;
    logic [7:0] dd, d1;
    dd = 8'($urandom);
    d1 = 8'($urandom);
    wr(uleb_pkg::OFS_MODE, md);
    rd(uleb_pkg::OFS_RXBUF, 1'b0, q, q2);
    d0 = n_done;
    e0 = n_err;
    if (pre) u_node.send_frame(d1, 1'b1, 1'b0, 1'b0, 1'b1);
    u_node.send_frame(dd, md[4:3] != 2'h0, md[4:3] == 2'h2, flip, stop_v);
    chk({8'(n_done - d0), 8'(n_err - e0)}, ie, "irq pulses");
    rd(uleb_pkg::OFS_STAT, 1'b1, q, q2);
    chk(16'(q), 16'(st), "status flags");
    chk(16'(q2), 16'h0000, "status after read");
    rd(uleb_pkg::OFS_RXBUF, 1'b0, q, q2);
    chk(16'(q), 16'(pre ? d1 : dd), "rx buffer");
  endtask

  task automatic results();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk_sys);
    n_errors++;
    $display("Error at %0t: run did not finish", $time);
    results();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    bus_req = '0;
    void'($urandom(71));
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), 1'b0, q, q2);
      chk(16'(q), 16'(RST_VAL[a]), "reset value");
    end
    wr(uleb_pkg::OFS_BRG_TX, 8'h08);
    wr(uleb_pkg::OFS_BRG_RX, 8'h08);
    wr(uleb_pkg::OFS_CLKSEL, 8'h00);
    wr(uleb_pkg::OFS_MODE, 8'hF8);
    chk(16'(serial_out_pin), 16'h0001, "idle level");
    done_test("reset");
    wr(uleb_pkg::OFS_CTRL, 8'h40);
    u_node.send_low(10);
    chk(16'(n_done + n_err), 16'h0000, "short break irq");
    rd(uleb_pkg::OFS_CTRL, 1'b0, q, q2);
    chk(16'(q), 16'h00C0, "short break keeps trigger");
    u_node.send_low(11);
    chk({8'(n_done), 8'(n_err)}, 16'h0100, "long break irq");
    rd(uleb_pkg::OFS_CTRL, 1'b0, q, q2);
    chk(16'(q), 16'h0000, "long break clears trigger");
    rd(uleb_pkg::OFS_STAT, 1'b0, q, q2);
    chk(16'(q), 16'h0000, "no flags in break");
    rd(uleb_pkg::OFS_RXBUF, 1'b0, q, q2);
    chk(16'(q), 16'h00FF, "buffer kept in break");
    done_test("break_rx");
    u_node.noise(2 * BT);
    chk(16'(n_done + n_err), 16'h0001, "noise ignored");
    done_test("noise");
    for (int m = 0; m < 4; m++) begin
      rx_case(8'hE0 | 8'(m << 3), 1'b1, 1'b1, 1'b0, par_stat(m), irq_exp(m >= 2, 1'b0));
    end
    rx_case(8'hF8, 1'b0, 1'b0, 1'b0, 8'h02, irq_exp(1'b1, 1'b0));
    rx_case(8'hF8, 1'b0, 1'b1, 1'b1, 8'h01, 16'h0101);
    rx_case(8'hF9, 1'b1, 1'b1, 1'b0, 8'h04, irq_exp(1'b1, 1'b1));
    done_test("rx_errors");
    for (int len = 0; len < 8; len++) begin
      e = n_txd;
      wr(uleb_pkg::OFS_CTRL, 8'h20 | 8'(len << 2));
      cnt = 0;
      #1;
      while (serial_out_pin !== 1'b0 && cnt < 8) begin
        @(posedge clk_sys);
        #1 cnt++;
      end
      cnt = 0;
      while (serial_out_pin === 1'b0 && cnt < 400) begin
        @(posedge clk_sys);
        #1 cnt++;
      end
      chk(16'(cnt), 16'((13 + len) * BT), "break low time");
      repeat (4) @(posedge clk_sys);
      chk(16'(n_txd - e), 16'h0001, "break done pulse");
      rd(uleb_pkg::OFS_CTRL, 1'b0, q, q2);
      chk(16'(q), 16'(len << 2), "break trigger cleared");
    end
    done_test("break_tx");
    results();
  end
endmodule
